// ---- core/tewc_pkg.sv ----
// package: register map, field positions, resets and clock-source codes for the event/window counter
package tewc_pkg;
    localparam logic [7:0]  ADDR_CTRL     = 8'h23;
    localparam logic [7:0]  ADDR_CMP_LO   = 8'h24;
    localparam logic [7:0]  ADDR_CMP_HI   = 8'h25;
    localparam int          CTRL_MODE_POS = 0;
    localparam int          CTRL_CK_LSB   = 2;
    localparam int          CTRL_RUN_POS  = 5;
    localparam logic [15:0] CMP_RESET     = 16'hFFFF;
    localparam logic [7:0]  CMP_LO_RESET  = 8'hFF;
    localparam logic [2:0]  CK_RESET      = 3'h0;
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam int          PM_WIDTH      = 2;
    typedef enum logic [2:0] {
        TEWC_CK_TAP0  = 3'h0,
        TEWC_CK_TAP1  = 3'h1,
        TEWC_CK_TAP2  = 3'h2,
        TEWC_CK_TAP3  = 3'h3,
        TEWC_CK_FAST  = 3'h4,
        TEWC_CK_SLOW  = 3'h5,
        TEWC_CK_RSVD  = 3'h6,
        TEWC_CK_PIN   = 3'h7
    } tewc_ck_t;
    // power state as seen by the counter
    typedef enum logic [1:0] {
        TEWC_PM_NORMAL = 2'h0,
        TEWC_PM_FIRST_LOW_SPEED_MODE  = 2'h1,
        TEWC_PM_SECOND_LOW_SPEED_MODE  = 2'h3,
        TEWC_PM_SLEEP  = 2'h2
    } tewc_pm_t;
    // divider taps, one pulse per tap period, from the clock/power block
    typedef struct packed {
        logic fc_div23;
        logic fc_div13;
        logic fc_div8;
        logic fc_div3;
        logic fc_tick;
        logic fs_div15;
        logic fs_div5;
        logic fs_tick;
    } tewc_taps_t;
endpackage

// ---- core/tewc_counter.sv ----
// 16-bit timer / event counter / window counter with two-byte compare register
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: three modes: internal timer, external edge count, gated window count.
// R2: control bit 0 picks window mode; pin clock source gives edge counting.
// R3: run bit 5 starts; clearing it stops and zeroes the counter.
// R4: codes 000..011 and 101 pick divider taps per power mode.
// R5: code 111 uses the count pin; code 110 is reserved.
// R6: code 100 is the raw fast clock, timer mode in second slow mode only.
// R7: software changes mode and source only while stopped.
// R8: compare written low then high; a lone byte write has no effect; here a lone high byte still loads with the raw fast clock selected.
// R9: old compare stays active until the high byte completes the pair.
// R10: software loads compare above 1, upper five bits above 1 at warm-up.
// R11: control bits 7, 6 and 1 read undefined; here they read zero.
// R12: entering stop mode clears the run bit automatically.
// R13: timer mode with fast or slow clock can time oscillator warm-up.
// R14: timer mode matches, pulses interrupt, clears and keeps counting.
// R15: raw fast clock in second slow mode matches upper five bits only.
// R16: event mode counts rising pin edges, resuming after each clear.
// R17: event mode checks the match on the pin's falling edge.
// R18: pin high and low each last at least two machine cycles.
// R19: window mode counts internal ticks while the pin is high.
// R20: window gate toggles much slower than the counting clock.
// R21: window mode unusable in slow and sleep; software stops first.
module tewc_counter
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // system state
    input  wire tewc_pkg::tewc_taps_t taps,
    input  wire tewc_pkg::tewc_pm_t   power_mode,
    input  wire logic                 stop_mode_entry,
    input  wire logic                 divider_base_select,
    // external count / gate pin
    input  wire logic                 count_pin,
    // match event
    output logic                      match_interrupt
);
    logic        pin_meta_ff;
    logic        pin_sync_ff;
    logic        pin_prev_ff;
    logic        run_ff;
    logic        mode_ff;
    logic [2:0]  ck_ff;
    logic [7:0]  lo_hold_ff;
    logic        lo_pend_ff;
    logic [15:0] cmp_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        irq_ff;
    logic [7:0]  rdata_ff;
    logic        tick;
    logic        pin_rise;
    logic        pin_fall;
    logic        hit;
    logic        fast_sel;
    logic        slow_pm;
    logic        nxt_irq;

    // pin is asynchronous to clk_sys, two stages before any use
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end
        else
        begin
            pin_meta_ff <= count_pin;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // the edge detector looks at the second stage and the stage after it, never the first
    AST_SYNC_STAGE: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
        pin_meta_ff != pin_sync_ff
        |=> pin_sync_ff == $past(pin_meta_ff))
        else $error("pin synchroniser skipped a stage");

    assign pin_rise = pin_sync_ff & ~pin_prev_ff;
    assign pin_fall = ~pin_sync_ff & pin_prev_ff;
    assign slow_pm  = (power_mode == tewc_pkg::TEWC_PM_FIRST_LOW_SPEED_MODE) || (power_mode == tewc_pkg::TEWC_PM_SECOND_LOW_SPEED_MODE)
                      || (power_mode == tewc_pkg::TEWC_PM_SLEEP);
    assign fast_sel = (ck_ff == tewc_pkg::TEWC_CK_FAST) && !mode_ff
                      && (power_mode == tewc_pkg::TEWC_PM_SECOND_LOW_SPEED_MODE); // [R6]

    // source clock select; codes 000 and 001 take low-frequency taps in slow modes or with divider base set
    always_comb
    begin
        unique case (tewc_pkg::tewc_ck_t'(ck_ff))
            tewc_pkg::TEWC_CK_TAP0: tick = (slow_pm || divider_base_select) ? taps.fs_div15 : taps.fc_div23; // [R4]
            tewc_pkg::TEWC_CK_TAP1: tick = (slow_pm || divider_base_select) ? taps.fs_div5 : taps.fc_div13;  // [R4]
            tewc_pkg::TEWC_CK_TAP2: tick = !slow_pm && taps.fc_div8;   // [R4]
            tewc_pkg::TEWC_CK_TAP3: tick = !slow_pm && taps.fc_div3;   // [R4]
            tewc_pkg::TEWC_CK_FAST: tick = fast_sel && taps.fc_tick;   // [R6] [R13]
            tewc_pkg::TEWC_CK_SLOW: tick = !slow_pm && taps.fs_tick;   // [R4] [R13]
            tewc_pkg::TEWC_CK_RSVD: tick = 1'b0;                       // [R5]
            tewc_pkg::TEWC_CK_PIN:  tick = pin_rise;                   // [R5] [R16]
        endcase
    end

    // the raw fast clock is refused unless timer mode runs in the second slow mode
    AST_FAST_GATED: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        run_ff && ck_ff == tewc_pkg::TEWC_CK_FAST && !fast_sel && !hit
        |=> $stable(cnt_ff))
        else $error("fast clock counted outside its mode");

    AST_RSVD_IDLE: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        run_ff && !mode_ff && ck_ff == 3'h6 && !hit |=> $stable(cnt_ff))
        else $error("reserved source counted");

    // fast source compares the upper five bits only; event mode checks on the falling edge
    assign hit = fast_sel ? (cnt_ff[15:11] == cmp_ff[15:11]) : (cnt_ff == cmp_ff); // [R15]

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_irq = 1'b0;
        if (!run_ff)
        begin
            nxt_cnt = tewc_pkg::CNT_RESET; // [R3]
        end
        else if (mode_ff)
        begin
            // window: internal ticks gated by the pin; no count in slow modes
            if (ck_ff == tewc_pkg::TEWC_CK_PIN || slow_pm)
                nxt_cnt = cnt_ff;
            else if (hit)
            begin
                nxt_cnt = tewc_pkg::CNT_RESET; // [R19]
                nxt_irq = 1'b1;
            end
            else if (tick && pin_sync_ff)
                nxt_cnt = cnt_ff + 16'h0001;   // [R19]
        end
        else if (ck_ff == tewc_pkg::TEWC_CK_PIN)
        begin
            if (pin_fall && hit)
            begin
                nxt_cnt = tewc_pkg::CNT_RESET; // [R17]
                nxt_irq = 1'b1;
            end
            else if (pin_rise)
                nxt_cnt = cnt_ff + 16'h0001;   // [R16]
        end
        else if (hit)
        begin
            nxt_cnt = tewc_pkg::CNT_RESET;     // [R14]
            nxt_irq = 1'b1;
        end
        else if (tick)
            nxt_cnt = cnt_ff + 16'h0001;       // [R14]
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_ff <= tewc_pkg::CNT_RESET;
            irq_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt; // [R1]
            irq_ff <= nxt_irq;
        end
    end

    assign match_interrupt = irq_ff;

    // each counter step depends only on the cycle before it
    AST_STOP_CLEARS: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        !run_ff |=> cnt_ff == 16'h0000)
        else $error("counter not zero while stopped");

    AST_MATCH_CLEARS: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
        irq_ff |-> cnt_ff == 16'h0000)
        else $error("counter not cleared on match");

    AST_EVENT_FALL: assert property (@(posedge clk_sys) disable iff (rst) // [R17]
        run_ff && !mode_ff && ck_ff == 3'h7 && nxt_irq |-> pin_fall)
        else $error("event match away from falling edge");

    AST_WINDOW_GATE: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
        run_ff && mode_ff && !pin_sync_ff && !nxt_irq |=> $stable(cnt_ff) || !$past(run_ff))
        else $error("window counted with gate low");

    AST_TIMER_STEP: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
        run_ff && !mode_ff && ck_ff != 3'h7 && !hit && tick
        |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("timer missed a tick");

    AST_EVENT_RISE: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
        run_ff && !mode_ff && ck_ff == 3'h7 && pin_rise
        |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("event counter missed a rising edge");

    AST_EVENT_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [R17]
        run_ff && !mode_ff && ck_ff == 3'h7 && !pin_rise && !pin_fall
        |=> $stable(cnt_ff))
        else $error("event counter moved without a pin edge");

    AST_WINDOW_STEP: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
        run_ff && mode_ff && ck_ff != 3'h7 && !slow_pm && !hit && tick && pin_sync_ff
        |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("window missed a tick with gate high");

    AST_SLOW_WINDOW: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
        run_ff && mode_ff && slow_pm
        |=> $stable(cnt_ff))
        else $error("window counted in a slow mode");

    AST_IRQ_PULSE: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
        irq_ff && !fast_sel && cmp_ff > 16'h0001
        |=> !irq_ff)
        else $error("match interrupt longer than one cycle");

    AST_IRQ_SOURCE: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
        irq_ff
        |-> $past(run_ff))
        else $error("match interrupt while stopped");

    // control register; stop-mode entry wins over a same-cycle write of the run bit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            run_ff  <= 1'b0;
            mode_ff <= 1'b0;
            ck_ff   <= tewc_pkg::CK_RESET;
        end
        else
        begin
            if (reg_wr && reg_addr == tewc_pkg::ADDR_CTRL)
            begin
                run_ff  <= reg_wdata[tewc_pkg::CTRL_RUN_POS];  // [R3]
                mode_ff <= reg_wdata[tewc_pkg::CTRL_MODE_POS]; // [R2]
                ck_ff   <= reg_wdata[tewc_pkg::CTRL_CK_LSB +: 3];
            end
            if (stop_mode_entry)
                run_ff <= 1'b0; // [R12]
        end
    end

    AST_STOP_ENTRY: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
        stop_mode_entry |=> !run_ff)
        else $error("run bit survived stop entry");

    AST_CTRL_WRITE: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        reg_wr && reg_addr == tewc_pkg::ADDR_CTRL
        |=> mode_ff == $past(reg_wdata[tewc_pkg::CTRL_MODE_POS]))
        else $error("mode bit not written");

    AST_RUN_WRITE: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        reg_wr && reg_addr == tewc_pkg::ADDR_CTRL && !stop_mode_entry
        |=> run_ff == $past(reg_wdata[tewc_pkg::CTRL_RUN_POS]))
        else $error("run bit not written");

    // compare pair: low byte parks, high byte commits both together
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lo_hold_ff <= tewc_pkg::CMP_LO_RESET;
            lo_pend_ff <= 1'b0;
            cmp_ff     <= tewc_pkg::CMP_RESET;
        end
        else if (reg_wr && reg_addr == tewc_pkg::ADDR_CMP_LO)
        begin
            lo_hold_ff <= reg_wdata; // [R9]
            lo_pend_ff <= 1'b1;
        end
        else if (reg_wr && reg_addr == tewc_pkg::ADDR_CMP_HI)
        begin
            lo_pend_ff <= 1'b0;
            if (lo_pend_ff)
                cmp_ff <= {reg_wdata, lo_hold_ff}; // [R8] [R9]
            else if (fast_sel)
                cmp_ff <= {reg_wdata, cmp_ff[7:0]}; // [R15]
        end
    end

    AST_LONE_HIGH: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
        reg_wr && reg_addr == 8'h25 && !lo_pend_ff && !fast_sel |=> $stable(cmp_ff))
        else $error("lone high byte changed compare");

    AST_LOW_HOLDS: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        reg_wr && reg_addr == 8'h24 |=> $stable(cmp_ff))
        else $error("low byte changed active compare");

    AST_PAIR_COMMIT: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        reg_wr && reg_addr == 8'h25 && lo_pend_ff |=> cmp_ff == {$past(reg_wdata), $past(lo_hold_ff)})
        else $error("pair not committed");

    AST_FAST_HIGH: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
        reg_wr && reg_addr == tewc_pkg::ADDR_CMP_HI && !lo_pend_ff && fast_sel
        |=> cmp_ff == {$past(reg_wdata), $past(cmp_ff[7:0])})
        else $error("high byte alone not taken for fast clock");

    AST_PEND_SET: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        reg_wr && reg_addr == tewc_pkg::ADDR_CMP_LO
        |=> lo_pend_ff && lo_hold_ff == $past(reg_wdata))
        else $error("low byte not parked");

    AST_PEND_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
        reg_wr && reg_addr == tewc_pkg::ADDR_CMP_HI
        |=> !lo_pend_ff)
        else $error("parked low byte survived a high write");

    // read data one cycle after the strobe; undefined control bits read zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata_ff <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                tewc_pkg::ADDR_CTRL:   rdata_ff <= {2'h0, run_ff, ck_ff, 1'b0, mode_ff}; // [R11]
                tewc_pkg::ADDR_CMP_LO: rdata_ff <= cmp_ff[7:0];
                tewc_pkg::ADDR_CMP_HI: rdata_ff <= cmp_ff[15:8];
                default:               rdata_ff <= 8'h00;
            endcase
        end
        else
            rdata_ff <= 8'h00;
    end

    assign reg_rdata = rdata_ff;

    AST_CTRL_READ: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
        reg_rd && reg_addr == 8'h23 |=> reg_rdata[7:6] == 2'h0 && reg_rdata[1] == 1'b0)
        else $error("undefined control bits not zero");

    AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
        !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    AST_CMP_LOW_READ: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        reg_rd && reg_addr == tewc_pkg::ADDR_CMP_LO
        |=> reg_rdata == $past(cmp_ff[7:0]))
        else $error("compare low byte read wrong");

    AST_CMP_HIGH_READ: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        reg_rd && reg_addr == tewc_pkg::ADDR_CMP_HI
        |=> reg_rdata == $past(cmp_ff[15:8]))
        else $error("compare high byte read wrong");
endmodule
`default_nettype wire

// ---- verification/tewc_pin_source.sv ----
// external count / gate pulse source for the counter pin
`timescale 1ns/1ns
`default_nettype none
module tewc_pin_source
#(
    parameter int HOLD_CYCLES = 6
)
(
    // clock
    input  wire logic clk_sys,
    // driven pin
    output var  logic count_pin
);
    initial count_pin = 1'b0;
    // each level outlasts the pin synchroniser by a margin
    task automatic rise();
        @(posedge clk_sys);
        count_pin <= 1'b1;
        repeat (HOLD_CYCLES) @(posedge clk_sys);
    endtask
    task automatic fall();
        @(posedge clk_sys);
        count_pin <= 1'b0;
        repeat (HOLD_CYCLES) @(posedge clk_sys);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            rise();
            fall();
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/test_timer_event_window_counter16.sv ----
// self-checking testbench for the timer / event / window counter
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_timer_event_window_counter16;
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         reg_rdata;
    logic [7:0]         tap_bits = 8'h00;
    tewc_pkg::tewc_pm_t power_mode = tewc_pkg::TEWC_PM_NORMAL;
    logic               stop_mode_entry = 1'b0;
    logic               divider_base_select = 1'b0;
    logic               count_pin;
    logic               match_interrupt;
    int                 bad_count = 0;
    int                 total_checks = 0;
    int                 irq_n = 0;
    int                 base;
    int                 codes [7] = '{0, 1, 2, 3, 5, 0, 1};
    int                 bits [7] = '{7, 6, 5, 4, 0, 2, 1};
    always #5 clk_sys = ~clk_sys;
    tewc_counter i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .taps(tewc_pkg::tewc_taps_t'(tap_bits)),
        .power_mode(power_mode), .stop_mode_entry(stop_mode_entry),
        .divider_base_select(divider_base_select), .count_pin(count_pin), .match_interrupt(match_interrupt));
    tewc_pin_source i_src (.clk_sys(clk_sys), .count_pin(count_pin));
    always @(posedge clk_sys)
        if (match_interrupt === 1'b1)
            irq_n <= irq_n + 1;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic tick(input int b);
        @(posedge clk_sys);
        tap_bits[b] <= 1'b1;
        @(posedge clk_sys);
        tap_bits[b] <= 1'b0;
    endtask
    // n-1 ticks give nothing, the n-th gives exactly one match
    task automatic tick_chk(input int b, input int n);
        int b0;
        b0 = irq_n;
        repeat (n - 1) tick(b);
        repeat (4) @(posedge clk_sys);
        `CHK(irq_n, b0)
        tick(b);
        repeat (4) @(posedge clk_sys);
        `CHK(irq_n, b0 + 1)
    endtask
    // mode and source are set while stopped, then the run bit follows
    task automatic setup(input logic [7:0] c, input logic [15:0] v);
        wr(tewc_pkg::ADDR_CTRL, c);
        wr(tewc_pkg::ADDR_CMP_LO, v[7:0]);
        wr(tewc_pkg::ADDR_CMP_HI, v[15:8]);
        wr(tewc_pkg::ADDR_CTRL, c | 8'h20);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(tewc_pkg::ADDR_CTRL, 8'h00);
        rd(tewc_pkg::ADDR_CMP_LO, 8'hFF);
        rd(tewc_pkg::ADDR_CMP_HI, 8'hFF);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        wr(tewc_pkg::ADDR_CTRL, 8'hDE);
        rd(tewc_pkg::ADDR_CTRL, 8'h1C);
        $display("register test done");
        for (int i = 0; i < 7; i++)
        begin
            divider_base_select <= (i > 4);
            setup(8'(codes[i] << 2), 16'h0003);
            tick_chk(bits[i], 3);
            tick_chk(bits[i], 3);
            wr(tewc_pkg::ADDR_CTRL, 8'(codes[i] << 2));
        end
        divider_base_select <= 1'b0;
        $display("source table test done");
        setup(8'h0C, 16'h0003);
        repeat (2) tick(4);
        wr(tewc_pkg::ADDR_CTRL, 8'h0C);
        wr(tewc_pkg::ADDR_CTRL, 8'h2C);
        tick_chk(4, 3);
        wr(tewc_pkg::ADDR_CMP_LO, 8'h05);
        tick_chk(4, 3);
        wr(tewc_pkg::ADDR_CMP_HI, 8'h00);
        tick_chk(4, 5);
        rd(tewc_pkg::ADDR_CMP_LO, 8'h05);
        wr(tewc_pkg::ADDR_CMP_HI, 8'h01);
        rd(tewc_pkg::ADDR_CMP_HI, 8'h00);
        tick_chk(4, 5);
        @(posedge clk_sys);
        stop_mode_entry <= 1'b1;
        @(posedge clk_sys);
        stop_mode_entry <= 1'b0;
        rd(tewc_pkg::ADDR_CTRL, 8'h0C);
        $display("compare and stop test done");
        setup(8'h1C, 16'h0003);
        base = irq_n;
        i_src.pulse(2);
        i_src.rise();
        `CHK(irq_n, base)
        i_src.fall();
        `CHK(irq_n, base + 1)
        i_src.pulse(3);
        `CHK(irq_n, base + 2)
        wr(tewc_pkg::ADDR_CTRL, 8'h1C);
        $display("event test done");
        setup(8'h0D, 16'h0003);
        base = irq_n;
        repeat (5) tick(4);
        repeat (4) @(posedge clk_sys);
        `CHK(irq_n, base)
        i_src.rise();
        tick_chk(4, 3);
        i_src.fall();
        wr(tewc_pkg::ADDR_CTRL, 8'h0D);
        $display("window test done");
        power_mode <= tewc_pkg::TEWC_PM_SECOND_LOW_SPEED_MODE;
        setup(8'h00, 16'h0003);
        repeat (3) tick(7);
        tick_chk(2, 3);
        wr(tewc_pkg::ADDR_CTRL, 8'h00);
        $display("slow tap test done");
        wr(tewc_pkg::ADDR_CTRL, 8'h10);
        wr(tewc_pkg::ADDR_CMP_HI, 8'h10);
        wr(tewc_pkg::ADDR_CTRL, 8'h30);
        base = irq_n;
        tap_bits[3] <= 1'b1;
        repeat (4080) @(posedge clk_sys);
        `CHK(irq_n, base)
        repeat (40) @(posedge clk_sys);
        `CHK(irq_n, base + 1)
        tap_bits[3] <= 1'b0;
        wr(tewc_pkg::ADDR_CTRL, 8'h10);
        $display("fast clock test done");
        final_report();
    end
    initial
    begin
        #(20000 * 10);
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
